// ---- inc/kbd_map.svh ----
// Register addresses, field positions and reset values of the keyboard port
`ifndef KBD_MAP_SVH
`define KBD_MAP_SVH

// Register byte addresses
`define KBD_STATUS_ADDR 32'hFFF82804
`define KBD_MODE_ADDR 32'hFFF82808
`define KBD_CMD_ADDR 32'hFFF8280C
`define KBD_DATA_ADDR 32'hFFF82830
`define KBD_LINE_CTRL_ADDR 32'hFFF82834

// Status fields
`define KBD_ST_TXCLK_DIS 7
`define KBD_ST_ONE 6
`define KBD_ST_FE 5
`define KBD_ST_OE 4
`define KBD_ST_PE 3
`define KBD_ST_STC 2
`define KBD_ST_RXFULL 1
`define KBD_ST_TXEMPTY 0

// Frame mode fields (first mode register)
`define KBD_MD1_STOP_HI 7
`define KBD_MD1_STOP_LO 6
`define KBD_MD1_PAR_EVEN 5
`define KBD_MD1_PAR_EN 4
`define KBD_MD1_LEN_HI 3
`define KBD_MD1_LEN_LO 2

// Command fields
`define KBD_CMD_ERR_CLR 4
`define KBD_CMD_BREAK 3
`define KBD_CMD_RX_EN 2
`define KBD_CMD_INHIBIT 1
`define KBD_CMD_TX_EN 0

// Line control fields
`define KBD_LC_TXCLK_DIS 0
`define KBD_LC_CLK_HOLD 1

// Reset values
`define KBD_MD1_RST 8'h5D
`define KBD_MD2_RST 8'h00
`define KBD_CMD_RST 8'h00

`endif

// ---- inc/kbd_pkg.sv ----
// Types shared by the keyboard serial port
package kbd_pkg;
	typedef logic [1:0] kbd_resp_t;
	localparam kbd_resp_t KBD_RESP_OKAY = 2'h0;
	localparam kbd_resp_t KBD_RESP_SLVERR = 2'h2;
	typedef enum logic [0:0] {
		KBD_PTR_ONE = 1'b0,
		KBD_PTR_TWO = 1'b1
	} kbd_mode_ptr_e;
	typedef enum logic [0:0] {
		KBD_TX_IDLE = 1'b0,
		KBD_TX_SEND = 1'b1
	} kbd_tx_state_e;
endpackage : kbd_pkg

// ---- logic/kbd_bit_sync.sv ----
// Two-stage synchroniser for one pin
`timescale 1ns/100ps
module kbd_bit_sync (
	input wire logic core_clk, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic rst_val, // Idle level of the pin
	input wire logic pin_in, // Asynchronous pin
	output logic pin_sync // Synchronised level
);
	logic meta_ff;

	// First stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (srst) begin
			meta_ff <= rst_val;
			pin_sync <= rst_val; // Idle level, so no false edge
		end else if (ce) begin
			meta_ff <= pin_in;
			pin_sync <= meta_ff;
		end
	end
endmodule : kbd_bit_sync

// ---- logic/kbd_rx_deser.sv ----
// Receive deserialiser for keyboard frames
`timescale 1ns/100ps
module kbd_rx_deser (
	input wire logic core_clk, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic enable, // Receiver enabled
	input wire logic fall, // Keyboard clock falling edge
	input wire logic din, // Synchronised data line
	input wire logic par_en, // Parity enabled
	input wire logic par_even, // Even parity when 1
	input wire logic [1:0] len_sel, // Data bits minus five
	output logic done, // One-cycle pulse, frame ended
	output logic [7:0] data, // Received character
	output logic perr, // Parity error of last frame
	output logic ferr // Framing error of last frame
);
	logic busy_ff;
	logic par_ff;
	logic [3:0] cnt_ff;
	logic [7:0] sh_ff;
	logic [3:0] n_data;
	logic is_data;
	logic is_par;
	logic [1:0] align;

	assign n_data = 4'h5 + {2'h0, len_sel};
	assign is_data = cnt_ff < n_data;
	assign is_par = par_en && (cnt_ff == n_data);
	assign align = 2'h3 - len_sel;

	// Bits arrive LSB first; data is valid at the falling edge
	always_ff @(posedge core_clk) begin
		if (srst) begin
			busy_ff <= 1'b0;
			par_ff <= 1'b0;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			done <= 1'b0;
			data <= 8'h00;
			perr <= 1'b0;
			ferr <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (!enable) begin
				busy_ff <= 1'b0;
			end else if (fall && !busy_ff) begin
				busy_ff <= !din; // Start bit is low
				cnt_ff <= 4'h0;
				par_ff <= 1'b0;
			end else if (fall && (is_data || is_par)) begin
				if (is_data) begin
					sh_ff <= {din, sh_ff[7:1]};
				end
				par_ff <= par_ff ^ din;
				cnt_ff <= cnt_ff + 4'h1;
			end else if (fall) begin
				// Stop bit: close the frame
				busy_ff <= 1'b0;
				done <= 1'b1;
				data <= sh_ff >> align;
				ferr <= !din;
				perr <= par_en && (par_ff == par_even);
			end
		end
	end
endmodule : kbd_rx_deser

// ---- logic/kbd_serial_top.sv ----
// Keyboard serial port: AXI4-Lite registers, receiver and transmitter
// Operation
// - Status bit 7 reads 1 while transmit clock is disabled, else 0.
// - Status bit 5 sets on framing error, stays until cleared.
// - Status bit 4 sets when a character overruns an unread holding byte.
// - Status bit 3 sets when a received character fails parity.
// - Status bit 2 sets on clock gate change or holding-to-shift load.
// - Status bit 1 is 1 while the receive holding byte is unread.
// - Status bit 0 shows whether transmit holding register is empty.
// - Status register is read-only; bit 6 always reads 1.
// - Two mode registers share one address; pointer alternates every access (a read and a write in one cycle leave it).
// - First mode bits 7-6 give stop bits (frames always use one stop bit), bits 3-2 data length.
// - First mode bit 4 enables parity; bit 5 at 0 means odd.
// - First mode bits 1-0 at 01 mean one sample per clock.
// - Second mode 00h takes both clocks from the keyboard clock line.
// - Command register reads back the command state last written.
// - Writing command bit 4 as 1 clears framing, overrun, parity and status change flags.
// - Command bit 3 at 0 means no break on the transmit line.
// - Command bit 2 enables the receiver.
// - Command bit 1 inhibits the keyboard from transmitting.
// - Command bit 0 enables the transmitter.
// - Keyboard clock held low at reset and when empty and inhibited.
// - Each received scan code raises a request and holds the clock low.
`timescale 1ns/100ps
`include "kbd_map.svh"
module kbd_serial_top (
	input wire logic core_clk, // System clock, 50 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic ce, // Clock enable, freezes all state
	input wire logic [31:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output kbd_pkg::kbd_resp_t s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [31:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output kbd_pkg::kbd_resp_t s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic kbd_clk_in, // Keyboard clock line level
	output logic kbd_clk_out, // Keyboard clock drive value
	output logic kbd_clk_oe, // Keyboard clock pulled low when 1
	input wire logic kbd_data_in, // Keyboard data line level
	output logic kbd_data_out, // Keyboard data drive value
	output logic kbd_data_oe, // Keyboard data pulled low when 1
	output logic kbd_rx_irq // Scan code waiting
);
	import kbd_pkg::*;

	// Register state
	logic [7:0] mode_register_one_ff;
	logic [7:0] mode_register_two_ff;
	logic [7:0] cmd_ff;
	kbd_mode_ptr_e mode_ptr_ff;
	logic [7:0] rhr_ff;
	logic receive_holding_full_ff;
	logic [7:0] thr_ff;
	logic thr_full_ff;
	logic framing_error_flag_ff;
	logic overrun_flag_ff;
	logic parity_error_flag_ff;
	logic status_change_flag_ff;
	logic tx_clock_disabled_flag_ff;
	logic clk_hold_ff;
	logic gate_prev_ff;

	// Transmitter state
	kbd_tx_state_e tx_state_ff;
	logic [3:0] tx_cnt_ff;
	logic [7:0] tx_sh_ff;

	// Bus handshake state
	logic awready_ff;
	logic arready_ff;

	// Link sampling
	logic kclk_s;
	logic kdat_s;
	logic kclk_d_ff;
	logic kclk_fall;

	// Receiver results
	logic rx_done;
	logic [7:0] rx_data;
	logic rx_perr;
	logic rx_ferr;

	// Command and mode fields
	logic force_break;
	logic receiver_enable;
	logic keyboard_tx_inhibit;
	logic transmitter_enable;
	logic parity_enable;
	logic parity_type;
	logic [1:0] character_length;

	assign force_break = cmd_ff[`KBD_CMD_BREAK];
	assign receiver_enable = cmd_ff[`KBD_CMD_RX_EN];
	assign keyboard_tx_inhibit = cmd_ff[`KBD_CMD_INHIBIT];
	assign transmitter_enable = cmd_ff[`KBD_CMD_TX_EN];
	assign parity_enable = mode_register_one_ff[`KBD_MD1_PAR_EN];
	assign parity_type = mode_register_one_ff[`KBD_MD1_PAR_EVEN];
	assign character_length =
		mode_register_one_ff[`KBD_MD1_LEN_HI:`KBD_MD1_LEN_LO];

	// Both link pins are asynchronous to core_clk
	kbd_bit_sync u_clk_sync (
		.core_clk(core_clk),
		.srst(srst),
		.ce(ce),
		.rst_val(1'b1),
		.pin_in(kbd_clk_in),
		.pin_sync(kclk_s)
	);
	kbd_bit_sync u_dat_sync (
		.core_clk(core_clk),
		.srst(srst),
		.ce(ce),
		.rst_val(1'b1),
		.pin_in(kbd_data_in),
		.pin_sync(kdat_s)
	);

	// Falling edge of the keyboard clock; 1x sampling, one bit per edge
	assign kclk_fall = kclk_d_ff && !kclk_s;

	// Receiver ignores edges we make ourselves by holding the line
	kbd_rx_deser u_rx (
		.core_clk(core_clk),
		.srst(srst),
		.ce(ce),
		.enable(receiver_enable),
		.fall(kclk_fall && !clk_hold_ff),
		.din(kdat_s),
		.par_en(parity_enable),
		.par_even(parity_type),
		.len_sel(character_length),
		.done(rx_done),
		.data(rx_data),
		.perr(rx_perr),
		.ferr(rx_ferr)
	);

	// Bus decode
	logic wr_go;
	logic wr_fire;
	logic rd_go;
	logic rd_fire;
	logic wr_lane;
	logic wr_status;
	logic wr_mode;
	logic wr_cmd;
	logic wr_data;
	logic wr_line;
	logic wr_hit;
	logic rd_status;
	logic rd_mode;
	logic rd_cmd;
	logic rd_data;
	logic rd_line;
	logic rd_hit;
	logic [7:0] rd_byte;
	logic [7:0] status_byte;

	assign wr_go = s_axi_awvalid && s_axi_wvalid && !awready_ff &&
		!s_axi_bvalid;
	assign wr_fire = awready_ff && s_axi_awvalid && s_axi_wvalid;
	assign rd_go = s_axi_arvalid && !arready_ff && !s_axi_rvalid;
	assign rd_fire = arready_ff && s_axi_arvalid;
	assign wr_lane = wr_fire && s_axi_wstrb[0];
	assign wr_status = s_axi_awaddr == `KBD_STATUS_ADDR;
	assign wr_mode = wr_lane && (s_axi_awaddr == `KBD_MODE_ADDR);
	assign wr_cmd = wr_lane && (s_axi_awaddr == `KBD_CMD_ADDR);
	assign wr_data = wr_lane && (s_axi_awaddr == `KBD_DATA_ADDR);
	assign wr_line = wr_lane && (s_axi_awaddr == `KBD_LINE_CTRL_ADDR);
	assign wr_hit = (s_axi_awaddr == `KBD_MODE_ADDR) ||
		(s_axi_awaddr == `KBD_CMD_ADDR) ||
		(s_axi_awaddr == `KBD_DATA_ADDR) ||
		(s_axi_awaddr == `KBD_LINE_CTRL_ADDR);
	assign rd_status = s_axi_araddr == `KBD_STATUS_ADDR;
	assign rd_mode = s_axi_araddr == `KBD_MODE_ADDR;
	assign rd_cmd = s_axi_araddr == `KBD_CMD_ADDR;
	assign rd_data = s_axi_araddr == `KBD_DATA_ADDR;
	assign rd_line = s_axi_araddr == `KBD_LINE_CTRL_ADDR;
	assign rd_hit = rd_status || rd_mode || rd_cmd || rd_data || rd_line;

	// Status image; bit 6 is hardwired high
	assign status_byte = {tx_clock_disabled_flag_ff, 1'b1,
		framing_error_flag_ff, overrun_flag_ff,
		parity_error_flag_ff, status_change_flag_ff,
		receive_holding_full_ff, !thr_full_ff};

	// Read mux; the mode pointer picks which mode register answers
	assign rd_byte = rd_status ? status_byte :
		(rd_mode && mode_ptr_ff == KBD_PTR_ONE) ? mode_register_one_ff :
		rd_mode ? mode_register_two_ff :
		rd_cmd ? cmd_ff :
		rd_data ? rhr_ff :
		rd_line ? {6'h00, clk_hold_ff, tx_clock_disabled_flag_ff} :
		8'h00;

	// Transmit frame: start, data LSB first, optional parity, stop
	logic tx_empty;
	logic tx_load;
	logic [3:0] tx_n_data;
	logic [3:0] tx_last;
	logic [7:0] tx_mask;
	logic tx_par;
	logic tx_bit;
	logic tx_clk_fall;

	assign tx_empty = (tx_state_ff == KBD_TX_IDLE) && !thr_full_ff;
	assign tx_load = (tx_state_ff == KBD_TX_IDLE) && thr_full_ff &&
		transmitter_enable;
	assign tx_n_data = 4'h5 + {2'h0, character_length};
	assign tx_last = tx_n_data + {3'h0, parity_enable} + 4'h1;
	assign tx_mask = 8'hFF >> (2'h3 - character_length);
	assign tx_par = ^(tx_sh_ff & tx_mask) ^ !parity_type;
	assign tx_bit = (tx_cnt_ff == 4'h0) ? 1'b0 :
		(tx_cnt_ff <= tx_n_data) ? tx_sh_ff[tx_cnt_ff[2:0] - 3'h1] :
		(parity_enable && tx_cnt_ff == tx_n_data + 4'h1) ? tx_par :
		1'b1;
	// Transmit clock only advances while the gate lets it through
	assign tx_clk_fall = kclk_fall && !tx_clock_disabled_flag_ff;

	// Auto inhibit: transmitter drained while keyboard is inhibited
	logic auto_inhibit;
	assign auto_inhibit = tx_empty && keyboard_tx_inhibit;

	// Next values of the flags; a hardware set beats a software clear
	logic err_clr;
	logic rhr_load;
	logic nxt_fe;
	logic nxt_oe;
	logic nxt_pe;
	logic nxt_stc;
	logic nxt_rx_full;
	logic nxt_gate_dis;
	logic nxt_hold;
	logic nxt_thr_full;

	assign err_clr = wr_cmd && s_axi_wdata[`KBD_CMD_ERR_CLR];
	assign rhr_load = rx_done && (!receive_holding_full_ff ||
		(rd_fire && rd_data));
	assign nxt_fe = (rx_done && rx_ferr) ||
		(framing_error_flag_ff && !err_clr);
	assign nxt_oe = (rx_done && !rhr_load) ||
		(overrun_flag_ff && !err_clr);
	assign nxt_pe = (rx_done && rx_perr) ||
		(parity_error_flag_ff && !err_clr);
	assign nxt_stc = tx_load ||
		(gate_prev_ff != tx_clock_disabled_flag_ff) ||
		(status_change_flag_ff && !err_clr);
	assign nxt_rx_full = rhr_load ||
		(receive_holding_full_ff && !(rd_fire && rd_data));
	assign nxt_gate_dis = auto_inhibit ? 1'b1 :
		wr_line ? s_axi_wdata[`KBD_LC_TXCLK_DIS] :
		tx_clock_disabled_flag_ff;
	assign nxt_hold = (auto_inhibit || rx_done) ? 1'b1 :
		wr_line ? s_axi_wdata[`KBD_LC_CLK_HOLD] : clk_hold_ff;
	assign nxt_thr_full = wr_data || (thr_full_ff && !tx_load);

	// Write and read address channels; readies pulse one cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			awready_ff <= 1'b0;
			arready_ff <= 1'b0;
		end else if (ce) begin
			awready_ff <= wr_go;
			arready_ff <= rd_go;
		end
	end
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = awready_ff;
	assign s_axi_arready = arready_ff;

	// Write response channel; status is read-only, unmapped answers error
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= KBD_RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_hit && !wr_status) ? KBD_RESP_OKAY :
					KBD_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read data channel
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= KBD_RESP_OKAY;
		end else if (ce) begin
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_hit ? KBD_RESP_OKAY : KBD_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Mode registers and the shared-address pointer
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode_register_one_ff <= `KBD_MD1_RST;
			mode_register_two_ff <= `KBD_MD2_RST;
			mode_ptr_ff <= KBD_PTR_ONE;
		end else if (ce) begin
			if (wr_mode && mode_ptr_ff == KBD_PTR_ONE) begin
				mode_register_one_ff <= s_axi_wdata[7:0];
			end
			if (wr_mode && mode_ptr_ff == KBD_PTR_TWO) begin
				mode_register_two_ff <= s_axi_wdata[7:0];
			end
			// A read or a write alone moves the pointer on; both in one cycle leave it
			if ((wr_fire && s_axi_awaddr == `KBD_MODE_ADDR) !=
				(rd_fire && rd_mode)) begin
				mode_ptr_ff <= (mode_ptr_ff == KBD_PTR_ONE) ?
					KBD_PTR_TWO : KBD_PTR_ONE;
			end
		end
	end

	// Command register holds exactly what was written
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmd_ff <= `KBD_CMD_RST;
		end else if (ce && wr_cmd) begin
			cmd_ff <= s_axi_wdata[7:0];
		end
	end

	// Status flags and holding registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			framing_error_flag_ff <= 1'b0;
			overrun_flag_ff <= 1'b0;
			parity_error_flag_ff <= 1'b0;
			status_change_flag_ff <= 1'b0;
			receive_holding_full_ff <= 1'b0;
			thr_full_ff <= 1'b0;
			rhr_ff <= 8'h00;
			thr_ff <= 8'h00;
		end else if (ce) begin
			framing_error_flag_ff <= nxt_fe;
			overrun_flag_ff <= nxt_oe;
			parity_error_flag_ff <= nxt_pe;
			status_change_flag_ff <= nxt_stc;
			receive_holding_full_ff <= nxt_rx_full;
			thr_full_ff <= nxt_thr_full;
			if (rhr_load) begin
				rhr_ff <= rx_data; // Overrun keeps the unread byte
			end
			if (wr_data) begin
				thr_ff <= s_axi_wdata[7:0];
			end
		end
	end

	// Line control; reset holds the clock and closes the transmit gate
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tx_clock_disabled_flag_ff <= 1'b1;
			gate_prev_ff <= 1'b1;
			clk_hold_ff <= 1'b1;
			kclk_d_ff <= 1'b1;
		end else if (ce) begin
			tx_clock_disabled_flag_ff <= nxt_gate_dis;
			gate_prev_ff <= tx_clock_disabled_flag_ff;
			clk_hold_ff <= nxt_hold;
			kclk_d_ff <= kclk_s;
		end
	end

	// Transmitter: load from holding register, shift on gated clock
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tx_state_ff <= KBD_TX_IDLE;
			tx_cnt_ff <= 4'h0;
			tx_sh_ff <= 8'h00;
		end else if (ce) begin
			case (tx_state_ff)
				KBD_TX_IDLE: begin
					if (tx_load) begin
						tx_state_ff <= KBD_TX_SEND;
						tx_cnt_ff <= 4'h0;
						tx_sh_ff <= thr_ff;
					end
				end
				KBD_TX_SEND: begin
					if (!transmitter_enable) begin
						tx_state_ff <= KBD_TX_IDLE;
					end else if (tx_clk_fall && tx_cnt_ff == tx_last) begin
						tx_state_ff <= KBD_TX_IDLE;
					end else if (tx_clk_fall) begin
						tx_cnt_ff <= tx_cnt_ff + 4'h1;
					end
				end
				default: begin
					tx_state_ff <= KBD_TX_IDLE;
				end
			endcase
		end
	end

	// Pin drivers; open drain, so only a low is ever driven
	always_ff @(posedge core_clk) begin
		if (srst) begin
			kbd_clk_out <= 1'b0;
			kbd_clk_oe <= 1'b1;
			kbd_data_out <= 1'b0;
			kbd_data_oe <= 1'b0;
			kbd_rx_irq <= 1'b0;
		end else if (ce) begin
			kbd_clk_out <= 1'b0;
			kbd_clk_oe <= nxt_hold;
			kbd_data_out <= 1'b0;
			kbd_data_oe <= force_break ||
				(tx_state_ff == KBD_TX_SEND && !tx_bit);
			kbd_rx_irq <= nxt_rx_full;
		end
	end
endmodule : kbd_serial_top

// ---- tb/kbd_serial_asserts.sv ----
// Checker for the keyboard port's register bus and line pins
`timescale 1ns/100ps
`include "kbd_map.svh"
module kbd_serial_asserts (
	input wire logic core_clk, // Clock
	input wire logic srst, // Reset
	input wire logic [31:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	input wire logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte enables
	input wire logic s_axi_wvalid, // Write data valid
	input wire logic s_axi_wready, // Write data ready
	input wire kbd_pkg::kbd_resp_t s_axi_bresp, // Write response
	input wire logic s_axi_bvalid, // Response valid
	input wire logic [31:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire kbd_pkg::kbd_resp_t s_axi_rresp, // Read response
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic kbd_clk_out, // Clock drive value
	input wire logic kbd_clk_oe, // Clock pulled low
	input wire logic kbd_data_oe, // Data pulled low
	input wire logic kbd_rx_irq // Scan code waiting
);
	import kbd_pkg::*;
	logic [31:0] wa_ff;
	logic [31:0] ra_ff;
	logic [7:0] cmd_ff;
	// Shadow of the command byte and the addresses under way
	always_ff @(posedge core_clk) begin
		if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
		if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
		if (srst) cmd_ff <= 8'h00;
		else if (s_axi_wvalid && s_axi_wready && s_axi_wstrb[0] &&
			s_axi_awaddr == `KBD_CMD_ADDR) cmd_ff <= s_axi_wdata[7:0];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	chk_reset_hold: assert property ($fell(srst) |-> kbd_clk_oe)
		else $error("keyboard clock not held after reset");
	chk_clk_low_only: assert property (kbd_clk_oe |-> !kbd_clk_out)
		else $error("keyboard clock driven high");
	chk_rx_hold: assert property ($rose(kbd_rx_irq) |->
		##[0:1] kbd_clk_oe)
		else $error("clock not held after scan code");
	chk_rx_enabled: assert property ($rose(kbd_rx_irq) |-> cmd_ff[2])
		else $error("character taken with receiver off");
	chk_status_one: assert property (s_axi_rvalid &&
		ra_ff == `KBD_STATUS_ADDR |-> s_axi_rdata[6] && s_axi_rdata[31:8] == 0)
		else $error("status bit 6 not one");
	chk_status_wr: assert property (s_axi_bvalid &&
		wa_ff == `KBD_STATUS_ADDR |-> s_axi_bresp == KBD_RESP_SLVERR)
		else $error("status write accepted");
	chk_read_clears: assert property (s_axi_rvalid && s_axi_rready &&
		ra_ff == `KBD_DATA_ADDR |=> !kbd_rx_irq)
		else $error("holding byte still full after read");
	chk_tx_enabled: assert property ($rose(kbd_data_oe) |->
		cmd_ff[0] || cmd_ff[3])
		else $error("data line driven with transmitter off");
endmodule : kbd_serial_asserts

bind kbd_serial_top kbd_serial_asserts i_kbd_serial_asserts (.core_clk, .srst,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .kbd_clk_out, .kbd_clk_oe, .kbd_data_oe, .kbd_rx_irq);

// ---- tb/kbd_key_model.sv ----
// Keyboard model sending framed scan codes on open-drain lines
`timescale 1ns/100ps
module kbd_key_model (
	output logic clk_lo, // Model pulls clock low
	output logic dat_lo // Model pulls data low
);
	// Lines released at start; pull-ups give the idle high
	initial begin
		clk_lo = 1'h0;
		dat_lo = 1'h0;
	end
	// Start, eight bits LSB first, odd parity, stop; clock idles high
	task automatic send(input logic [7:0] code, input logic bad_par,
		input logic bad_stop);
		logic [10:0] bits;
		bits = {~bad_stop, ~^code ^ bad_par, code, 1'h0};
		#3;
		for (int i = 0; i < 11; i++) begin
			dat_lo = ~bits[i];
			#40 clk_lo = 1'h1;
			#80 clk_lo = 1'h0;
			#40;
		end
		dat_lo = 1'h0;
	endtask : send
endmodule : kbd_key_model

// ---- tb/tb_keyboard_serial_interface.sv ----
// Self-checking bench of the keyboard serial port
`timescale 1ns/100ps
`include "kbd_map.svh"
module tb_keyboard_serial_interface;
	import kbd_pkg::*;
	localparam logic [31:0] ST = `KBD_STATUS_ADDR;
	localparam logic [31:0] MD = `KBD_MODE_ADDR;
	localparam logic [31:0] CM = `KBD_CMD_ADDR;
	localparam logic [31:0] DT = `KBD_DATA_ADDR;
	localparam logic [31:0] LC = `KBD_LINE_CTRL_ADDR;
	localparam kbd_resp_t OK = KBD_RESP_OKAY;
	logic core_clk = 1'h0;
	logic srst = 1'h1;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, kbd_clk_out, kbd_clk_oe, kbd_data_out, kbd_data_oe;
	logic kbd_rx_irq, clk_lo, dat_lo;
	logic [31:0] s_axi_rdata;
	kbd_resp_t s_axi_bresp, s_axi_rresp;
	int n_errors = 0;
	int checked = 0;
	// Open-drain lines with pull-ups
	wire kbd_clk = !(kbd_clk_oe === 1'h1 || clk_lo);
	wire kbd_dat = !(kbd_data_oe === 1'h1 || dat_lo);

	kbd_serial_top i_kbd_serial_top (.core_clk, .srst, .ce(1'h1),
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .kbd_clk_in(kbd_clk), .kbd_clk_out, .kbd_clk_oe,
		.kbd_data_in(kbd_dat), .kbd_data_out, .kbd_data_oe, .kbd_rx_irq);
	kbd_key_model i_kbd_key_model (.clk_lo, .dat_lo);

	always #10 core_clk = ~core_clk;

	task automatic end_of_test;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One clock with a bound on the whole wait
	task automatic tick(inout int n);
		@(posedge core_clk);
		n++;
		if (n > 3000) begin
			n_errors++;
			end_of_test();
		end
	endtask : tick

	task automatic wr(input logic [31:0] a, input logic [7:0] d,
		input kbd_resp_t er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do tick(n); while (s_axi_awready !== 1'h1);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		do tick(n); while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, er);
		tick(n);
	endtask : wr

	task automatic rd(input logic [31:0] a, output logic [33:0] v);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do tick(n); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do tick(n); while (s_axi_rvalid !== 1'h1);
		v = {s_axi_rresp, s_axi_rdata};
		s_axi_rready <= 1'h0;
		tick(n);
	endtask : rd

	task automatic rdchk(input logic [31:0] a, input logic [33:0] e);
		logic [33:0] v;
		rd(a, v);
		chk(v, e);
	endtask : rdchk

	// Poll status until one of the masked bits is set
	task automatic wst(input logic [7:0] m);
		logic [33:0] v;
		int n;
		n = 0;
		do begin
			rd(ST, v);
			tick(n);
		end while ((v[7:0] & m) == 8'h0);
	endtask : wst

	// Release the keyboard clock, then let the keyboard send one frame
	task automatic key(input logic [7:0] c, input logic bp, input logic bs);
		wr(LC, 8'h01, OK);
		i_kbd_key_model.send(c, bp, bs);
		@(posedge core_clk);
	endtask : key

	task automatic t_reset;
		chk(kbd_clk_oe, 1'h1);
		chk(kbd_data_oe, 1'h0);
		rdchk(ST, 34'hC1);
		rdchk(MD, 34'h5D);
		rdchk(MD, 34'h00);
		rdchk(CM, 34'h00);
		wr(ST, 8'h00, KBD_RESP_SLVERR);
		rdchk(ST, 34'hC1);
		rdchk(32'hFFF82800, 34'h200000000);
	endtask : t_reset

	task automatic t_regs;
		wr(MD, 8'h4D, OK);
		wr(MD, 8'h00, OK);
		rdchk(MD, 34'h4D);
		rdchk(MD, 34'h00);
		wr(MD, 8'h5D, OK);
		wr(MD, 8'h00, OK);
		wr(CM, 8'h05, OK);
		rdchk(CM, 34'h05);
		wr(CM, 8'h00, OK);
		key(8'h1C, 1'h0, 1'h0);
		rdchk(ST, 34'hC1);
	endtask : t_regs

	task automatic t_rx;
		wr(CM, 8'h04, OK);
		key(8'h1C, 1'h0, 1'h0);
		wst(8'h02);
		chk(kbd_rx_irq, 1'h1);
		chk(kbd_clk_oe, 1'h1);
		rdchk(ST, 34'hC3);
		rdchk(DT, 34'h1C);
		rdchk(ST, 34'hC1);
		key(8'hA5, 1'h1, 1'h0);
		wst(8'h02);
		rdchk(ST, 34'hCB);
		rdchk(ST, 34'hCB);
		rdchk(DT, 34'hA5);
		key(8'h3C, 1'h0, 1'h1);
		wst(8'h02);
		rdchk(ST, 34'hEB);
		rdchk(DT, 34'h3C);
		key(8'h11, 1'h0, 1'h0);
		wst(8'h02);
		key(8'h22, 1'h0, 1'h0);
		wst(8'h10);
		rdchk(ST, 34'hFB);
		wr(CM, 8'h14, OK);
		rdchk(ST, 34'hC3);
		rdchk(DT, 34'h11);
	endtask : t_rx

	task automatic t_tx;
		wr(LC, 8'h00, OK);
		rdchk(ST, 34'h45);
		wr(CM, 8'h10, OK);
		wr(DT, 8'h5A, OK);
		rdchk(ST, 34'h40);
		wr(CM, 8'h01, OK);
		rdchk(ST, 34'h45);
		chk(kbd_data_oe, 1'h1);
		// Transmitter off and keyboard inhibited: auto hold and gate close
		wr(CM, 8'h02, OK);
		rdchk(ST, 34'hC5);
		chk(kbd_clk_oe, 1'h1);
		chk(kbd_data_oe, 1'h0);
		chk(kbd_data_out, 1'h0);
	endtask : t_tx

	// Reset, then the scenarios in order
	initial begin
		repeat (16) @(posedge core_clk);
		srst <= 1'h0;
		@(posedge core_clk);
		t_reset();
		t_regs();
		t_rx();
		t_tx();
		end_of_test();
	end
endmodule : tb_keyboard_serial_interface
